// File: common/pcd_defines.vh
`ifndef PCD_DEFINES_VH
`define PCD_DEFINES_VH
// memory locations (command byte location field)
`define PCD_LOC_WIPER      4'h0
`define PCD_LOC_TERMINAL_CONNECTION_CONTROL       4'h4
// command byte field positions
`define PCD_CMD_LOC_MSB    7
`define PCD_CMD_LOC_LSB    4
`define PCD_CMD_OP_MSB     3
`define PCD_CMD_OP_LSB     2
`define PCD_CMD_SPARE_BIT  1
`define PCD_CMD_NINTH_BIT  0
// operation codes
`define PCD_OP_WRITE       2'h0
`define PCD_OP_INC         2'h1
`define PCD_OP_DEC         2'h2
`define PCD_OP_READ        2'h3
// general call command codes (upper six bits of the byte)
`define PCD_GC_WR_WIPER    6'h20
`define PCD_GC_WR_TERMINAL_CONNECTION_CONTROL     6'h30
`define PCD_GC_INC         6'h21
`define PCD_GC_DEC         6'h22
// reset values and limits
`define PCD_WIPER_RST      9'h080
`define PCD_TERMINAL_CONNECTION_CONTROL_RST       8'hff
`define PCD_WIPER_FULL8    9'h100
`define PCD_WIPER_FULL7    9'h080
// bit clock counts per sequence
`define PCD_CLK_SINGLE_WR  29
`define PCD_CLK_SINGLE_INC 20
`endif

// File: logic/pcd_regfile.v
`timescale 1ns/10ps
`include "pcd_defines.vh"
// two-location volatile store: wiper and terminal control, registered read
module pcd_regfile #(
   parameter WIPER_W = 9
) (
   input  wire               i_sys_clk,
   input  wire               i_resetn,
   input  wire               i_wr_en,
   input  wire [3:0]         i_wr_loc,
   input  wire [7:0]         i_wr_data,
   input  wire               i_inc,
   input  wire               i_dec,
   input  wire [WIPER_W-1:0] i_full,
   input  wire [3:0]         i_rd_loc,
   output reg  [7:0]         o_rd_data,
   output wire [WIPER_W-1:0] o_wiper,
   output wire [7:0]         o_terminal_connection_control
);
   reg [WIPER_W-1:0] wiper_q;
   reg [7:0]         terminal_connection_control_q;

   assign o_wiper = wiper_q;
   assign o_terminal_connection_control  = terminal_connection_control_q;

   ///////////////////////////////////////////////////////////////////////
   // storage updates
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wiper_q <= `PCD_WIPER_RST;
         terminal_connection_control_q  <= `PCD_TERMINAL_CONNECTION_CONTROL_RST;
      end else begin
         if (i_wr_en && i_wr_loc == `PCD_LOC_WIPER) begin
            wiper_q <= {{(WIPER_W-8){1'b0}}, i_wr_data};
         end else if (i_inc && wiper_q < i_full) begin
            wiper_q <= wiper_q + 1'b1;
         end else if (i_dec && wiper_q != {WIPER_W{1'b0}}) begin
            wiper_q <= wiper_q - 1'b1;
         end
         if (i_wr_en && i_wr_loc == `PCD_LOC_TERMINAL_CONNECTION_CONTROL) begin
            terminal_connection_control_q <= i_wr_data;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // registered read port
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rd_data <= 8'h00;
      end else if (i_rd_loc == `PCD_LOC_TERMINAL_CONNECTION_CONTROL) begin
         o_rd_data <= terminal_connection_control_q;
      end else begin
         o_rd_data <= wiper_q[7:0];
      end
   end
endmodule // pcd_regfile

// File: logic/pcd_decoder.v
`timescale 1ns/10ps
`include "pcd_defines.vh"
//////////////////////////////////////////////////////////////////////////
module pcd_decoder #(
   parameter WIPER_W   = 9,
   parameter EIGHT_BIT = 1
) (
   input  wire               i_sys_clk,
   input  wire               i_resetn,
   input  wire               i_start,
   input  wire               i_stop,
   input  wire               i_gen_call,
   input  wire               i_rx_valid,
   input  wire [7:0]         i_rx_byte,
   input  wire               i_rd_req,
   output reg                o_ack_valid,
   output reg                o_ack,
   output reg                o_tx_valid,
   output reg  [7:0]         o_tx_byte,
   output reg                o_error,
   output wire [WIPER_W-1:0] o_wiper,
   output wire [7:0]         o_terminal_connection_control
);
   // sequence walk, one state per expected byte kind:
   // idle    no frame open, bytes are dropped unanswered
   // cmd     command byte expected, fields checked for a legal pair
   // data    data byte of a write expected, stored at its ack point
   // gc      general call command byte expected
   // gcd     third byte of a general call write expected
   // lock    lockout, every byte refused until a new start
   // a start always wins, so a cut write never reaches storage
   // a stop drops back to idle but keeps the error flag raised
   // continuous writes loop data back to cmd without a new start
   // increment and decrement stay in cmd, they carry no data byte
   // a general call takes one command only, then locks out
   // lockout always raises the error flag, and reads stop while in lockout
   // reads alternate a zero high byte and the stored low byte
   // the read toggle is restarted high by every start
   // the read location follows the last legal write or read command byte outside a general call
   // it starts at the wiper location after reset
   // states
   localparam ST_IDLE = 3'h0;
   localparam ST_CMD  = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_GC   = 3'h3;
   localparam ST_GCD  = 3'h4;
   localparam ST_LOCK = 3'h5;

   // sequence state and latched locations
   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg  [3:0] loc_q;
   reg  [3:0] loc_d;
   reg  [3:0] rd_loc_q;
   reg  [3:0] rd_loc_d;
   reg        rd_hi_q;
   reg        rd_hi_d;
   // combinational strobes to storage and answer
   reg        wr_en;
   reg  [7:0] wr_data;
   reg        inc;
   reg        dec;
   reg        ack_v;
   reg        ack;
   reg        err;
   // read data and decoded fields
   wire [7:0] rd_data;
   wire [3:0] cmd_location_field;
   wire [1:0] cmd_operation_field;
   wire       cmd_spare_high_bit;
   wire       cmd_ninth_data_bit;
   // validity, general call code and full scale
   wire       combo_ok;
   wire [5:0] gc_code;
   wire [WIPER_W-1:0] full;

   ///////////////////////////////////////////////////////////////////////
   // command byte fields and validity
   // location in the top nibble, operation below it
   // the two low bits are spare data bits, kept for format only
   // only the wiper allows all four operations
   // terminal control allows write and read only
   // every other location is reserved and refused
   // general call code drops its don't-care bit and the zero lsb
   // full scale depends on the resolution variant
   // the fields are read straight off the received byte
   // so they are only meaningful while a byte is valid
   assign cmd_location_field  = i_rx_byte[`PCD_CMD_LOC_MSB:`PCD_CMD_LOC_LSB];
   assign cmd_operation_field = i_rx_byte[`PCD_CMD_OP_MSB:`PCD_CMD_OP_LSB];
   assign cmd_spare_high_bit  = i_rx_byte[`PCD_CMD_SPARE_BIT];
   assign cmd_ninth_data_bit  = i_rx_byte[`PCD_CMD_NINTH_BIT];
   assign combo_ok = (cmd_location_field == `PCD_LOC_WIPER) ||
                     (cmd_location_field == `PCD_LOC_TERMINAL_CONNECTION_CONTROL &&
                      (cmd_operation_field == `PCD_OP_WRITE ||
                       cmd_operation_field == `PCD_OP_READ));
   assign gc_code = i_rx_byte[7:2];
   assign full = EIGHT_BIT ? `PCD_WIPER_FULL8 : `PCD_WIPER_FULL7;

   ///////////////////////////////////////////////////////////////////////
   // sequence decoder
   // frame events first: start, then stop, then a received byte
   // answers and strobes default low, so only one path raises them
   // store strobes act on the same edge that takes the byte
   // inc and dec saturate inside the storage module
   always @* begin
      state_d  = state_q;
      loc_d    = loc_q;
      rd_loc_d = rd_loc_q;
      rd_hi_d  = rd_hi_q;
      wr_en    = 1'b0;
      wr_data  = i_rx_byte;
      inc      = 1'b0;
      dec      = 1'b0;
      ack_v    = 1'b0;
      ack      = 1'b0;
      err      = 1'b0;
      if (i_start) begin
         // a new start clears lockout and aborts any open data
         // a general call frame expects its command first
         state_d = i_gen_call ? ST_GC : ST_CMD;
         rd_hi_d = 1'b1;
      end else if (i_stop) begin
         // stop ends the frame, an open write is dropped
         state_d = ST_IDLE;
      end else if (i_rx_valid) begin
         case (state_q)
            ST_CMD: begin
               // command byte: legal pairs are acknowledged
               // write waits for its data byte
               // read only moves the read location
               // an illegal pair refuses and locks out
               ack_v = 1'b1;
               if (combo_ok) begin
                  ack = 1'b1;
                  if (cmd_operation_field == `PCD_OP_WRITE) begin
                     loc_d    = cmd_location_field;
                     rd_loc_d = cmd_location_field;
                     state_d  = ST_DATA;
                  end else if (cmd_operation_field == `PCD_OP_INC) begin
                     inc = 1'b1;
                  end else if (cmd_operation_field == `PCD_OP_DEC) begin
                     dec = 1'b1;
                  end else begin
                     rd_loc_d = cmd_location_field;
                  end
               end else begin
                  err     = 1'b1;
                  state_d = ST_LOCK;
               end
            end
            ST_DATA: begin
               // ack clock of the data byte commits the store
               // the two high data bits never reach this byte
               ack_v   = 1'b1;
               ack     = 1'b1;
               wr_en   = 1'b1;
               state_d = ST_CMD;
            end
            ST_GC: begin
               // one general call command, then lockout with the flag raised
               ack_v = 1'b1;
               if (i_rx_byte[0] == 1'b0 && (gc_code == `PCD_GC_WR_WIPER ||
                   gc_code == `PCD_GC_WR_TERMINAL_CONNECTION_CONTROL)) begin
                  ack     = 1'b1;
                  loc_d   = gc_code == `PCD_GC_WR_WIPER ? `PCD_LOC_WIPER : `PCD_LOC_TERMINAL_CONNECTION_CONTROL;
                  state_d = ST_GCD;
               end else if (i_rx_byte[0] == 1'b0 && gc_code == `PCD_GC_INC) begin
                  ack     = 1'b1;
                  inc     = 1'b1;
                  err     = 1'b1;
                  state_d = ST_LOCK;
               end else if (i_rx_byte[0] == 1'b0 && gc_code == `PCD_GC_DEC) begin
                  ack     = 1'b1;
                  dec     = 1'b1;
                  err     = 1'b1;
                  state_d = ST_LOCK;
               end else begin
                  // codes of other devices and reserved ones: refuse, no action
                  err     = 1'b1;
                  state_d = ST_LOCK;
               end
            end
            ST_GCD: begin
               ack_v   = 1'b1;
               ack     = 1'b1;
               wr_en   = 1'b1;
               err     = 1'b1;
               state_d = ST_LOCK;
            end
            ST_LOCK: begin
               // refused and ignored until the next start
               ack_v = 1'b1;
               err   = 1'b1;
            end
            default: begin
               // idle and unknown states leave bytes unanswered
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // state and answer registers
   // answers are registered, one cycle after the byte
   // the error flag is cleared only by a start
   // a start and an error never meet, the start path sets no error
   // the read byte toggle restarts high at every start
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q     <= ST_IDLE;
         loc_q       <= `PCD_LOC_WIPER;
         rd_loc_q    <= `PCD_LOC_WIPER;
         rd_hi_q     <= 1'b1;
         o_ack_valid <= 1'b0;
         o_ack       <= 1'b0;
         o_error     <= 1'b0;
      end else begin
         state_q     <= state_d;
         loc_q       <= loc_d;
         rd_loc_q    <= rd_loc_d;
         rd_hi_q     <= (i_rd_req && !i_start) ? ~rd_hi_q : rd_hi_d;
         o_ack_valid <= ack_v;
         o_ack       <= ack;
         if (i_start) begin
            o_error <= 1'b0;
         end else if (err) begin
            o_error <= 1'b1;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // read bytes: zero high byte, then stored data
   // a read request answers the next cycle, outside lockout
   // the first byte after a start is all zero
   // the second carries the stored byte of the read location
   // storage read data is registered, so it settles a cycle early
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_tx_valid <= 1'b0;
         o_tx_byte  <= 8'h00;
      end else begin
         o_tx_valid <= i_rd_req && state_q != ST_LOCK;
         o_tx_byte  <= rd_hi_q ? 8'h00 : rd_data;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // storage: wiper and terminal control
   // writes use the location latched from the command byte
   // reads use the last location named by a write or read command byte outside a general call
   // full scale sets where increments stop
   pcd_regfile #(
      .WIPER_W (WIPER_W)
   ) u_regfile (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_wr_en   (wr_en),
      .i_wr_loc  (loc_q),
      .i_wr_data (wr_data),
      .i_inc     (inc),
      .i_dec     (dec),
      .i_full    (full),
      .i_rd_loc  (rd_loc_q),
      .o_rd_data (rd_data),
      .o_wiper   (o_wiper),
      .o_terminal_connection_control    (o_terminal_connection_control)
   );
endmodule // pcd_decoder

// File: verif/pcd_chk.sv
`timescale 1ns/10ps
// watches the decoder ports for answer timing, lockout and register stability
module pcd_chk #(
   parameter WIPER_W = 9
) (
   input wire logic               i_sys_clk,
   input wire logic               i_resetn,
   input wire logic               i_start,
   input wire logic               i_stop,
   input wire logic               i_rx_valid,
   input wire logic               i_rd_req,
   input wire logic               o_ack_valid,
   input wire logic               o_ack,
   input wire logic               o_tx_valid,
   input wire logic               o_error,
   input wire logic [WIPER_W-1:0] o_wiper,
   input wire logic [7:0]         o_terminal_connection_control
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   // a byte or read request that is not overridden by a frame event
   sequence s_byte_in;
      i_rx_valid && !i_start && !i_stop;
   endsequence
   sequence s_read_in;
      i_rd_req && !o_error && !i_start && !i_stop && !i_rx_valid;
   endsequence
   a_ack_follows: assert property (s_byte_in |=> o_ack_valid)
      else $error("no answer after byte");
   a_tx_follows: assert property (s_read_in |=> o_tx_valid)
      else $error("no read byte after request");
   a_err_holds: assert property (o_error && !i_start |=> o_error)
      else $error("lockout left without start");
   a_err_clears: assert property (i_start |=> !o_error)
      else $error("lockout kept after start");
   a_lock_nack: assert property ((o_error and s_byte_in) |=> o_ack_valid && !o_ack)
      else $error("byte acknowledged in lockout");
   a_nack_err: assert property (o_ack_valid && !o_ack |-> o_error)
      else $error("refusal without lockout");
   a_wiper_cap: assert property (o_wiper <= 9'h100)
      else $error("wiper above full scale");
   a_idle_stable: assert property (!i_rx_valid |=> $stable(o_wiper) && $stable(o_terminal_connection_control))
      else $error("register moved without byte");
endmodule // pcd_chk

// File: verif/pcd_host.sv
`timescale 1ns/10ps
// byte-level bus host, drives at the falling edge
module pcd_host (
   input  wire logic       i_sys_clk,
   input  wire logic       i_ack_valid,
   input  wire logic       i_ack,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_byte,
   output logic            o_start,
   output logic            o_stop,
   output logic            o_gen_call,
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_byte,
   output logic            o_rd_req
);
   // all lines idle from time zero
   initial begin
      o_start = 1'b0;
      o_stop = 1'b0;
      o_gen_call = 1'b0;
      o_rx_valid = 1'b0;
      o_rx_byte = 8'h00;
      o_rd_req = 1'b0;
   end
   // start pulse, also used to leave a lockout after a refusal
   task automatic frame(input logic g);
      @(negedge i_sys_clk);
      o_start = 1;
      o_gen_call = g;
      @(negedge i_sys_clk);
      o_start = 0;
   endtask
   task automatic stop;
      @(negedge i_sys_clk);
      o_stop = 1;
      @(negedge i_sys_clk);
      o_stop = 0;
   endtask
   // one whole byte; released byte lines show the inverse
   task automatic put(input logic [7:0] b, output logic [1:0] a);
      @(negedge i_sys_clk);
      o_rx_valid = 1;
      o_rx_byte = b;
      @(negedge i_sys_clk);
      o_rx_valid = 0;
      o_rx_byte = ~b;
      a = {i_ack_valid, i_ack};
   endtask
   task automatic get(output logic [8:0] r);
      @(negedge i_sys_clk);
      o_rd_req = 1;
      @(negedge i_sys_clk);
      o_rd_req = 0;
      r = {i_tx_valid, i_tx_byte};
   endtask
endmodule // pcd_host

// File: verif/pot_i2c_command_decoder_tb.sv
`timescale 1ns/10ps
module pot_i2c_command_decoder_tb;
   logic clk = 0, rstn = 0, st, sp, gc, rv, rq, av, ak, tv, er;
   logic [7:0] rb, tx, tc;
   logic [8:0] wp, r;
   logic [1:0] a;
   int error_cnt = 0, n_compared = 0;
   typedef struct packed {logic g; logic [7:0] c; logic d; logic [7:0] v; logic k;
      logic [8:0] w; logic [7:0] t;} pcd_row_t;
   // gen call, command, has data, data, ack, wiper, terminal_connection_control after the row
   pcd_row_t rows[19] = '{'{0,8'h00,1,8'h55,1,9'h055,8'hff}, '{0,8'h03,1,8'ha5,1,9'h0a5,8'hff},
      '{0,8'h04,0,8'h00,1,9'h0a6,8'hff}, '{0,8'h08,0,8'h00,1,9'h0a5,8'hff},
      '{0,8'h40,1,8'h3c,1,9'h0a5,8'h3c}, '{0,8'h44,0,8'h00,0,9'h0a5,8'h3c},
      '{0,8'h1c,0,8'h00,0,9'h0a5,8'h3c}, '{0,8'h0c,0,8'h00,1,9'h0a5,8'h3c},
      '{1,8'h80,1,8'h12,1,9'h012,8'h3c}, '{1,8'h82,1,8'h34,1,9'h034,8'h3c},
      '{1,8'hc0,1,8'h5a,1,9'h034,8'h5a}, '{1,8'hc2,1,8'h6b,1,9'h034,8'h6b},
      '{1,8'h84,0,8'h00,1,9'h035,8'h6b}, '{1,8'h86,0,8'h00,1,9'h036,8'h6b},
      '{1,8'h88,0,8'h00,1,9'h035,8'h6b}, '{1,8'h8a,0,8'h00,1,9'h034,8'h6b},
      '{1,8'h06,0,8'h00,0,9'h034,8'h6b}, '{1,8'h04,0,8'h00,0,9'h034,8'h6b},
      '{1,8'h90,0,8'h00,0,9'h034,8'h6b}};
   always #50 clk = ~clk;
   pcd_host h_u (.i_sys_clk(clk), .i_ack_valid(av), .i_ack(ak), .i_tx_valid(tv),
      .i_tx_byte(tx), .o_start(st), .o_stop(sp), .o_gen_call(gc), .o_rx_valid(rv),
      .o_rx_byte(rb), .o_rd_req(rq));
   pcd_decoder dut_u (.i_sys_clk(clk), .i_resetn(rstn), .i_start(st), .i_stop(sp),
      .i_gen_call(gc), .i_rx_valid(rv), .i_rx_byte(rb), .i_rd_req(rq), .o_ack_valid(av),
      .o_ack(ak), .o_tx_valid(tv), .o_tx_byte(tx), .o_error(er), .o_wiper(wp), .o_terminal_connection_control(tc));
   task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic go(input logic [7:0] b);
      h_u.put(b, a);
      chk("ack", {7'h0, a}, 9'h003);
   endtask
   task automatic results;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog
   initial begin
      #2000000;
      error_cnt++;
      results;
   end
   // table rows, then saturation, lockout, abort and read-back
   initial begin
      repeat (12) @(negedge clk);
      rstn = 1;
      chk("wiper rst", wp, 9'h080);
      chk("terminal_connection_control rst", {1'b0, tc}, 9'h0ff);
      // read before any write comes from location zero
      h_u.frame(0);
      h_u.get(r);
      chk("read rst high", r, 9'h100);
      h_u.get(r);
      chk("read rst low", r, 9'h180);
      h_u.stop;
      foreach (rows[i]) begin
         h_u.frame(rows[i].g);
         h_u.put(rows[i].c, a);
         chk("cmd ack", {7'h0, a}, {8'h01, rows[i].k});
         if (rows[i].d) go(rows[i].v);
         chk("wiper", wp, rows[i].w);
         chk("terminal_connection_control", {1'b0, tc}, {1'b0, rows[i].t});
         h_u.stop;
      end
      h_u.frame(0);
      go(8'h00);
      go(8'hff);
      go(8'h04);
      go(8'h04);
      chk("wiper top", wp, 9'h100);
      go(8'h00);
      go(8'h01);
      go(8'h08);
      go(8'h08);
      chk("wiper zero", wp, 9'h000);
      h_u.frame(1);
      go(8'h84);
      h_u.put(8'h84, a);
      chk("gc again", {7'h0, a}, 9'h002);
      h_u.frame(0);
      h_u.put(8'h5c, a);
      h_u.put(8'h00, a);
      h_u.put(8'h42, a);
      chk("locked ack", {7'h0, a}, 9'h002);
      chk("wiper lock", wp, 9'h001);
      chk("error", {8'h0, er}, 9'h001);
      h_u.frame(0);
      chk("error", {8'h0, er}, 9'h000);
      go(8'h00);
      h_u.stop;
      chk("wiper abort", wp, 9'h001);
      h_u.frame(0);
      go(8'h40);
      go(8'h99);
      h_u.frame(0);
      h_u.get(r);
      chk("read high", r, 9'h100);
      h_u.get(r);
      chk("read low", r, 9'h199);
      h_u.stop;
      // reset in mid-run restores the chosen values
      rstn = 0;
      @(negedge clk);
      rstn = 1;
      chk("wiper rst2", wp, 9'h080);
      chk("terminal_connection_control rst2", {1'b0, tc}, 9'h0ff);
      chk("error rst2", {8'h0, er}, 9'h000);
      results;
   end
endmodule // pot_i2c_command_decoder_tb
bind pcd_decoder pcd_chk #(.WIPER_W(WIPER_W)) chk_u (.i_sys_clk, .i_resetn, .i_start, .i_stop,
   .i_rx_valid, .i_rd_req, .o_ack_valid, .o_ack, .o_tx_valid, .o_error, .o_wiper, .o_terminal_connection_control);
